//--- tb/gp_pin_model.sv
// outside circuitry on the three ports: resolves each pin level
// assumes the bench sets external drive values and per-port drive enables
module gp_pin_model (
	// clock
	input  wire logic       mclk,
	// design side
	input  wire logic [7:0] outA,
	input  wire logic [7:0] oeA,
	input  wire logic [7:0] outB,
	input  wire logic [7:0] oeB,
	input  wire logic [7:0] outC,
	input  wire logic [7:0] oeC,
	input  wire logic [7:0] pullUp,
	// bench side
	input  wire logic [7:0] extA,
	input  wire logic [7:0] extB,
	input  wire logic [7:0] extC,
	input  wire logic [2:0] extEn,
	// resolved pins
	output logic      [7:0] pinA,
	output logic      [7:0] pinB,
	output logic      [7:0] pinC
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] flt = 8'h55;
	// undriven pins without pull-up wander each cycle
	always_ff @(posedge mclk) begin
		flt <= ~flt;
	end
	// external level held until changed by the bench
	assign pinA = (oeA & outA) | (~oeA & (extEn[0] ? extA : (pullUp | flt)));
	assign pinB = (oeB & outB) | (~oeB & (extEn[1] ? extB : flt));
	assign pinC = (oeC & outC) | (~oeC & (extEn[2] ? extC : flt));
endmodule

//--- tb/tb_gp_ports.sv
// bench for the three-port pin block: register access tasks and checks
// assumes gp_pin_model resolves the pins
`include "gpio_cfg.svh"
module tb_gp_ports;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, bitOp = 1'b0, bitSet = 1'b0;
	logic dirLoad = 1'b0, pullWakeEnN = 1'b1, extResetMode = 1'b0, timerExtClk = 1'b0;
	logic [7:0] regAddr = 8'h00, regWdata = 8'h00, workReg = 8'h00, regRdata;
	logic [7:0] altFuncA = 8'h00, altFuncB = 8'h00, altFuncC = 8'h00;
	logic [7:0] extA = 8'h00, extB = 8'h00, extC = 8'h00, pinA, pinB, pinC;
	logic [7:0] outA, oeA, outB, oeB, outC, oeC, pullUp;
	logic [2:0] bitIdx = 3'h0, extEn = 3'h0;
	logic wakeEvent;
	gp_pkg::gp_port_sel_t dirSel = gp_pkg::GP_SEL_A;
	int fails = 0, cmp_count = 0, cycles = 0;
	always #2.5 mclk = ~mclk;
	gp_ports DUT (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWr(regWr),
		.regWdata(regWdata), .regRd(regRd), .bitOp(bitOp), .bitSet(bitSet),
		.bitIdx(bitIdx), .regRdata(regRdata), .dirLoad(dirLoad), .dirSel(dirSel),
		.workReg(workReg), .pullWakeEnN(pullWakeEnN), .extResetMode(extResetMode),
		.timerExtClk(timerExtClk), .altFuncA(altFuncA), .altFuncB(altFuncB),
		.altFuncC(altFuncC), .first_port_pins_in(pinA), .second_port_pins_in(pinB),
		.portCIn(pinC), .first_port_pins_out(outA), .first_port_pins_oe(oeA),
		.second_port_pins_out(outB), .second_port_pins_oe(oeB), .portCOut(outC),
		.portCOe(oeC), .pullUpEn(pullUp), .wakeEvent(wakeEvent));
	gp_pin_model PM (.mclk(mclk), .outA(outA), .oeA(oeA), .outB(outB), .oeB(oeB),
		.outC(outC), .oeC(oeC), .pullUp(pullUp), .extA(extA), .extB(extB),
		.extC(extC), .extEn(extEn), .pinA(pinA), .pinB(pinB), .pinC(pinC));
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regAddr = a; regWdata = d; regWr = 1'b1; cyc(1); regWr = 1'b0; cyc(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		cyc(5); regAddr = a; regRd = 1'b1; cyc(1); regRd = 1'b0; chk(regRdata, e);
	endtask
	task automatic dl(input gp_pkg::gp_port_sel_t s, input logic [7:0] w);
		dirSel = s; workReg = w; dirLoad = 1'b1; cyc(1); dirLoad = 1'b0; cyc(1);
	endtask
	task automatic wake(input logic e);
		logic seen;
		seen = 1'b0;
		repeat (8) begin
			cyc(1);
			seen = seen | wakeEvent;
		end
		chk({7'h00, seen}, {7'h00, e});
	endtask
	////////////////////////////////////////////////////////////////////////////
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			results();
		end
	end
	initial begin
		cyc(5); rst = 1'b0; cyc(1);
		chk(oeA | oeB | oeC, 8'h00);
		wr(`GP_ADDR_A, 8'hFF); wr(`GP_ADDR_B, 8'hFF);
		chk(outA, 8'h3F);
		chk(outB, 8'hF0);
		wr(`GP_ADDR_C, 8'hA5); dl(gp_pkg::GP_SEL_C, 8'h00); cyc(1);
		chk(oeC, 8'hFF);
		chk(outC, 8'hA5);
		rd(`GP_ADDR_C, 8'hA5);
		dl(gp_pkg::GP_SEL_C, 8'hFF); extC = 8'h3C; extEn = 3'h7; extA = 8'hFF; extB = 8'hFF;
		rd(`GP_ADDR_C, 8'h3C);
		chk(outC, 8'hA5);
		regAddr = `GP_ADDR_C; bitIdx = 3'h0; bitSet = 1'b1; bitOp = 1'b1; cyc(1);
		bitOp = 1'b0; cyc(1);
		chk(outC, 8'h3D);
		altFuncC = 8'h0F; rd(`GP_ADDR_C, 8'h30);
		rd(`GP_ADDR_A, 8'h3F);
		rd(`GP_ADDR_B, 8'hF0);
		rd(8'h10, 8'h00);
		dl(gp_pkg::GP_SEL_B, 8'h00); dl(gp_pkg::GP_SEL_A, 8'h00); cyc(1);
		chk(oeA, 8'h37);
		chk(oeB, 8'hF0);
		timerExtClk = 1'b1; cyc(2);
		chk(oeA, 8'h33);
		dl(gp_pkg::GP_SEL_A, 8'hFF); pullWakeEnN = 1'b0; cyc(6);
		chk(pullUp, 8'h1B);
		extA = 8'hFE; wake(1'b1);
		extA = 8'hEE; wake(1'b1);
		extResetMode = 1'b1; cyc(6); extA = 8'hE6; wake(1'b0);
		pullWakeEnN = 1'b1; cyc(2);
		chk(pullUp, 8'h08);
		results();
	end
endmodule

//--- verilog/gp_pkg.sv
// types for the three-port pin block
// assumes gpio_cfg.svh holds the constants
package gp_pkg;
	typedef enum logic [1:0] {
		GP_SEL_A,
		GP_SEL_B,
		GP_SEL_C
	} gp_port_sel_t;
endpackage

//--- verilog/gp_ports.sv
// three-port pin block: latches, direction control, pin readback, wake group
// assumes the core issues one access per instruction cycle on mclk
`include "gpio_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// [R1] port reads return live pin levels, never output latches
// [R2] every reset sets all direction bits, pins start as inputs
// [R3] first port has six bits; bits seven and six read zero
// [R4] input-only pin never drives
// [R5] pins given alternate function read zero
// [R6] pins zero, one, three, four have pull-ups and wake on change
// [R7] one common enable governs pull-up and wake for the group
// [R8] input-only pin as reset: pull-up forced on, wake disabled
// [R9] second port implements bits seven to four; low bits read zero
// [R10] third port implements all eight bits
// [R11] direction-load copies working register into selected direction register
// [R12] direction one tristates; zero drives the output latch
// [R13] timer option may force the timer clock pin to input
// [R14] direction registers are write-only and set at reset
// [R15] inputs are not latched; external driver holds level until read
// [R16] output latches hold until software writes again
// [R17] each pin except the reset pin has its own direction bit
// [R18] input-only direction bit stays one, ignores clears
// [R19] bit set and clear read pins, modify, write the addressed port's latch
// [R20] writes land at cycle end; reads sample at cycle start
module gp_ports (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// core register access
	input  wire logic [7:0] regAddr,
	input  wire logic       regWr,
	input  wire logic [7:0] regWdata,
	input  wire logic       regRd,
	input  wire logic       bitOp,
	input  wire logic       bitSet,
	input  wire logic [2:0] bitIdx,
	output logic      [7:0] regRdata,
	// direction load
	input  wire logic       dirLoad,
	input  wire gp_pkg::gp_port_sel_t dirSel,
	input  wire logic [7:0] workReg,
	// configuration
	input  wire logic       pullWakeEnN,
	input  wire logic       extResetMode,
	input  wire logic       timerExtClk,
	input  wire logic [7:0] altFuncA,
	input  wire logic [7:0] altFuncB,
	input  wire logic [7:0] altFuncC,
	// pins
	input  wire logic [7:0] first_port_pins_in,
	input  wire logic [7:0] second_port_pins_in,
	input  wire logic [7:0] portCIn,
	output logic      [7:0] first_port_pins_out,
	output logic      [7:0] first_port_pins_oe,
	output logic      [7:0] second_port_pins_out,
	output logic      [7:0] second_port_pins_oe,
	output logic      [7:0] portCOut,
	output logic      [7:0] portCOe,
	// pull and wake
	output logic      [7:0] pullUpEn,
	output logic            wakeEvent
);

	function automatic logic [7:0] implMask(input logic [7:0] a);
		case (a)
			`GP_ADDR_A:     implMask = `GP_MASK_A; // [R3]
			`GP_ADDR_B:     implMask = `GP_MASK_B; // [R9]
			`GP_ADDR_C:     implMask = `GP_MASK_C; // [R10]
			default:        implMask = `GP_ZERO8;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: three stages, change accepted when two and three agree
	logic [7:0] sA1_reg, sA2_reg, sA3_reg, pinA_reg;
	logic [7:0] sB1_reg, sB2_reg, sB3_reg, pinB_reg;
	logic [7:0] sC1_reg, sC2_reg, sC3_reg, pinC_reg;
	logic [7:0] pinA_next, pinB_next, pinC_next;

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : gFilt
			always_comb begin
				pinA_next[g] = (sA2_reg[g] == sA3_reg[g]) ? sA3_reg[g] : pinA_reg[g];
				pinB_next[g] = (sB2_reg[g] == sB3_reg[g]) ? sB3_reg[g] : pinB_reg[g];
				pinC_next[g] = (sC2_reg[g] == sC3_reg[g]) ? sC3_reg[g] : pinC_reg[g];
			end
		end
	endgenerate

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			{sA1_reg, sA2_reg, sA3_reg, pinA_reg} <= '0;
			{sB1_reg, sB2_reg, sB3_reg, pinB_reg} <= '0;
			{sC1_reg, sC2_reg, sC3_reg, pinC_reg} <= '0;
		end else begin
			sA1_reg  <= first_port_pins_in;
			sA2_reg  <= sA1_reg;
			sA3_reg  <= sA2_reg;
			pinA_reg <= pinA_next;
			sB1_reg  <= second_port_pins_in;
			sB2_reg  <= sB1_reg;
			sB3_reg  <= sB2_reg;
			pinB_reg <= pinB_next;
			sC1_reg  <= portCIn;
			sC2_reg  <= sC1_reg;
			sC3_reg  <= sC2_reg;
			pinC_reg <= pinC_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// live readback value, masked for width and alternate function
	logic [7:0] liveA, liveB, liveC, liveSel;
	always_comb begin
		liveA = pinA_reg & ~altFuncA & `GP_MASK_A; // [R1] [R3] [R5] [R15]
		liveB = pinB_reg & ~altFuncB & `GP_MASK_B; // [R9] [R5]
		liveC = pinC_reg & ~altFuncC & `GP_MASK_C; // [R10] [R5]
		case (regAddr)
			`GP_ADDR_A:     liveSel = liveA;
			`GP_ADDR_B:     liveSel = liveB;
			`GP_ADDR_C:     liveSel = liveC;
			default:        liveSel = `GP_ZERO8;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// output latches, direction registers, read data
	logic [7:0] latA_reg, latB_reg, latC_reg, latA_next, latB_next, latC_next;
	logic [7:0] dirA_reg, dirB_reg, dirC_reg, dirA_next, dirB_next, dirC_next;
	logic [7:0] rdata_reg, rdata_next, wval;
	logic       wrHit;

	always_comb begin
		latA_next  = latA_reg;
		latB_next  = latB_reg;
		latC_next  = latC_reg;
		dirA_next  = dirA_reg;
		dirB_next  = dirB_reg;
		dirC_next  = dirC_reg;
		rdata_next = rdata_reg;
		wval       = regWdata;
		wrHit      = regWr;
		if (bitOp) begin
			wval         = liveSel; // [R19]
			wval[bitIdx] = bitSet; // [R19]
			wrHit        = 1'b1;
		end
		if (wrHit) begin
			case (regAddr)
				`GP_ADDR_A:     latA_next = wval & implMask(regAddr); // [R16] [R20]
				`GP_ADDR_B:     latB_next = wval & implMask(regAddr); // [R16] [R20]
				`GP_ADDR_C:     latC_next = wval & implMask(regAddr); // [R16] [R20]
				default: ;
			endcase
		end
		if (regRd)
			rdata_next = liveSel; // [R1] [R20]
		if (dirLoad) begin
			case (dirSel)
				gp_pkg::GP_SEL_A: dirA_next = workReg | ~`GP_MASK_A; // [R11] [R17]
				gp_pkg::GP_SEL_B: dirB_next = workReg | ~`GP_MASK_B; // [R11]
				gp_pkg::GP_SEL_C: dirC_next = workReg; // [R11]
				default: ;
			endcase
		end
		dirA_next[`GP_INONLY_BIT] = 1'b1; // [R18] [R4]
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			latA_reg  <= `GP_ZERO8;
			latB_reg  <= `GP_ZERO8;
			latC_reg  <= `GP_ZERO8;
			dirA_reg  <= `GP_DIR_RESET; // [R2] [R14]
			dirB_reg  <= `GP_DIR_RESET; // [R2] [R14]
			dirC_reg  <= `GP_DIR_RESET; // [R2] [R14]
			rdata_reg <= `GP_ZERO8;
		end else begin
			latA_reg  <= latA_next;
			latB_reg  <= latB_next;
			latC_reg  <= latC_next;
			dirA_reg  <= dirA_next;
			dirB_reg  <= dirB_next;
			dirC_reg  <= dirC_next;
			rdata_reg <= rdata_next;
		end
	end
	assign regRdata = rdata_reg;

	////////////////////////////////////////////////////////////////////////////
	// pin drivers, pull-ups and wake detection
	logic [7:0] oeA_next, oeB_next, oeC_next, oeA_reg, oeB_reg, oeC_reg;
	logic [7:0] outA_reg, outB_reg, outC_reg;
	logic [7:0] pull_next, pull_reg, wakeMask, wakeRef_reg;
	logic       wake_next, wake_reg;

	always_comb begin
		oeA_next = ~dirA_next & `GP_MASK_A; // [R12]
		oeB_next = ~dirB_next & `GP_MASK_B; // [R12]
		oeC_next = ~dirC_next & `GP_MASK_C; // [R12]
		oeA_next[`GP_INONLY_BIT] = 1'b0; // [R4]
		if (timerExtClk)
			oeA_next[`GP_TCKI_BIT] = 1'b0; // [R13]
		pull_next = pullWakeEnN ? `GP_ZERO8 : `GP_PULL_GROUP; // [R6] [R7]
		wakeMask  = pull_next;
		if (extResetMode) begin
			pull_next[`GP_INONLY_BIT] = 1'b1; // [R8]
			wakeMask[`GP_INONLY_BIT]  = 1'b0; // [R8]
		end
		wake_next = |((pinA_reg ^ wakeRef_reg) & wakeMask); // [R6]
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			{oeA_reg, oeB_reg, oeC_reg}    <= '0;
			{outA_reg, outB_reg, outC_reg} <= '0;
			pull_reg    <= `GP_ZERO8;
			wakeRef_reg <= `GP_ZERO8;
			wake_reg    <= 1'b0;
		end else begin
			oeA_reg     <= oeA_next;
			oeB_reg     <= oeB_next;
			oeC_reg     <= oeC_next;
			outA_reg    <= latA_next;
			outB_reg    <= latB_next;
			outC_reg    <= latC_next;
			pull_reg    <= pull_next;
			wakeRef_reg <= pinA_reg;
			wake_reg    <= wake_next;
		end
	end

	assign first_port_pins_out  = outA_reg;
	assign first_port_pins_oe   = oeA_reg;
	assign second_port_pins_out = outB_reg;
	assign second_port_pins_oe  = oeB_reg;
	assign portCOut             = outC_reg;
	assign portCOe              = oeC_reg;
	assign pullUpEn             = pull_reg;
	assign wakeEvent            = wake_reg;

	////////////////////////////////////////////////////////////////////////////
	// checks
	AST_INONLY_NEVER_DRIVES: assert property (@(posedge mclk) disable iff (rst) // [R4]
		!first_port_pins_oe[`GP_INONLY_BIT]) else $error("input-only pin driven");
	AST_DIR_HIGH_BLOCKS: assert property (@(posedge mclk) disable iff (rst) // [R18]
		dirA_reg[`GP_INONLY_BIT]) else $error("input-only direction bit cleared");
	AST_UPPER_A_ZERO: assert property (@(posedge mclk) disable iff (rst) // [R3]
		$past(regRd) && $past(regAddr) == `GP_ADDR_A |-> (regRdata & ~`GP_MASK_A) == `GP_ZERO8)
		else $error("first port upper bits not zero");
	AST_LOW_B_ZERO: assert property (@(posedge mclk) disable iff (rst) // [R9]
		$past(regRd) && $past(regAddr) == `GP_ADDR_B |-> (regRdata & ~`GP_MASK_B) == `GP_ZERO8)
		else $error("second port low bits not zero");
	AST_READ_LIVE_C: assert property (@(posedge mclk) disable iff (rst) // [R1]
		regRd && regAddr == `GP_ADDR_C |=> regRdata == $past(pinC_reg & ~altFuncC))
		else $error("third port read not pin level");
	AST_DIR_LOAD_C: assert property (@(posedge mclk) disable iff (rst) // [R11]
		dirLoad && dirSel == gp_pkg::GP_SEL_C |=> portCOe == ~$past(workReg))
		else $error("direction load not applied");
	AST_LATCH_HOLDS: assert property (@(posedge mclk) disable iff (rst) // [R16]
		!regWr && !bitOp |=> portCOut == $past(portCOut))
		else $error("output latch changed without write");
	AST_RESET_PULL: assert property (@(posedge mclk) disable iff (rst) // [R8]
		extResetMode |=> pullUpEn[`GP_INONLY_BIT]) else $error("reset pin pull-up off");
	AST_GROUP_PULL: assert property (@(posedge mclk) disable iff (rst) // [R7]
		!pullWakeEnN |=> (pullUpEn & `GP_PULL_GROUP) == `GP_PULL_GROUP)
		else $error("pull group not common");
	COV_BIT_OP: cover property (@(posedge mclk) disable iff (rst) bitOp);
	COV_DIR_LOAD: cover property (@(posedge mclk) disable iff (rst) dirLoad);
	COV_WAKE: cover property (@(posedge mclk) disable iff (rst) wakeEvent);
	COV_EXT_RESET: cover property (@(posedge mclk) disable iff (rst) extResetMode);
	COV_TIMER_PIN: cover property (@(posedge mclk) disable iff (rst) timerExtClk);

	////////////////////////////////////////////////////////////////////////////
	// reset, direction, latch, pull, wake and unmapped read checks
	AST_RESET_DIR_SET: assert property (@(posedge mclk) disable iff (rst) // [R2]
		$fell(rst) |-> dirA_reg == `GP_DIR_RESET && dirB_reg == `GP_DIR_RESET
			&& dirC_reg == `GP_DIR_RESET) else $error("direction not set after reset");
	AST_DIR_LOAD_B: assert property (@(posedge mclk) disable iff (rst) // [R12]
		dirLoad && dirSel == gp_pkg::GP_SEL_B
			|=> second_port_pins_oe == (~$past(workReg) & `GP_MASK_B))
		else $error("second port direction not applied");
	AST_LATCH_A_WRITE: assert property (@(posedge mclk) disable iff (rst) // [R16]
		regWr && !bitOp && regAddr == `GP_ADDR_A
			|=> first_port_pins_out == ($past(regWdata) & `GP_MASK_A))
		else $error("first port latch not written");
	AST_LATCH_B_WRITE: assert property (@(posedge mclk) disable iff (rst) // [R9]
		regWr && !bitOp && regAddr == `GP_ADDR_B
			|=> second_port_pins_out == ($past(regWdata) & `GP_MASK_B))
		else $error("second port latch not written");
	AST_TIMER_PIN_INPUT: assert property (@(posedge mclk) disable iff (rst) // [R13]
		timerExtClk |=> !first_port_pins_oe[`GP_TCKI_BIT]) else $error("timer clock pin driven");
	AST_PULL_OFF: assert property (@(posedge mclk) disable iff (rst) // [R7]
		pullWakeEnN && !extResetMode |=> pullUpEn == `GP_ZERO8)
		else $error("pull-ups on while disabled");
	AST_WAKE_NEEDS_ENABLE: assert property (@(posedge mclk) disable iff (rst) // [R6]
		wakeEvent |-> !$past(pullWakeEnN)) else $error("wake without common enable");
	AST_UNMAPPED_READ: assert property (@(posedge mclk) disable iff (rst) // [R14]
		regRd && implMask(regAddr) == `GP_ZERO8 |=> regRdata == `GP_ZERO8)
		else $error("unmapped read not zero");
endmodule

//--- verilog/gpio_cfg.svh
// named constants for the three-port pin block
// assumes inclusion by bare name from the bench and design
`ifndef GPIO_CFG_SVH
`define GPIO_CFG_SVH
`define GP_ADDR_A         8'h06
`define GP_ADDR_B         8'h07
`define GP_ADDR_C         8'h27
`define GP_MASK_A         8'h3F
`define GP_MASK_B         8'hF0
`define GP_MASK_C         8'hFF
`define GP_INONLY_BIT     3
`define GP_TCKI_BIT       2
`define GP_DIR_RESET      8'hFF
`define GP_PULL_GROUP     8'h1B
`define GP_ZERO8          8'h00
`endif
